// [fp_status_control.sv]
// Floating-point status and control word with compare and result class logic.
// Contract
// - Condition code bits sit at 16 to 19.
// - Compare sets exactly one condition code bit.
// - Class bit plus code describe stored result.
// - Negative and NaN result flag codes.
// - Positive result flag codes.
// - Bit 22 flags invalid square root.
// - Bit 23 flags invalid integer convert.
// - Bits 24 to 28 enable five exceptions.
// - Bits 30 to 31 select rounding mode.
// - Exception bits stay set until moved.
// - Single format is 1, 8, 23 bits.
// - Double format is 1, 11, 52 bits.
// - Sign first, then exponent, then fraction.
// - Single bias 127, exponent -126 to 127.
// - Double bias 1023, exponent -1022 to 1023.
// - Significand is implied bit plus fraction.
// - Arithmetic operands are double format only.
// - NaN compares always give unordered.
// - Class bit sits at status bit 15.
// - Zero and denormal have exponent zero.
// - Maximum exponent is infinity or NaN.
`timescale 1ns/1ps
`include "fp_status_regs.svh"
module fp_status_control
    import fp_status_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        nrst,
    // Update from the execution unit.
    input  wire logic        upd_valid,
    input  wire logic        upd_compare,
    input  wire logic [63:0] cmp_a,
    input  wire logic [63:0] cmp_b,
    input  wire logic [63:0] res_value,
    input  wire logic        res_single,
    input  wire logic [3:12] exc_set,
    input  wire logic        inv_sqrt,
    input  wire logic        inv_cvt,
    input  wire logic        frac_rounded,
    input  wire logic        frac_inexact,
    // Move-to-status and copy-status requests.
    input  mv_op_t           mv_op,
    input  wire logic [0:31] mv_data,
    input  wire logic [0:7]  mv_mask,
    input  wire logic [2:0]  mv_field,
    input  wire logic [0:3]  mv_imm,
    input  wire logic [4:0]  mv_bit,
    // Status and control outputs.
    output logic [0:31]      status_word,
    output round_mode_t      rounding_mode,
    output logic [0:4]       exc_enables,
    output logic             trap_pulse,
    output logic [0:3]       copy_field
);

    // Classifier channels for both compare operands and both result formats.
    fp_class_if a_if ();
    fp_class_if b_if ();
    fp_class_if rd_if ();
    fp_class_if rs_if ();

    // Operand classifiers work on double format only.
    fp_classify #(.EXP_W(`DBL_EXP_W), .FRAC_W(`DBL_FRAC_W), .BIAS(`DBL_BIAS)) u_cls_a (
        .value (cmp_a),
        .cls   (a_if)
    );
    fp_classify #(.EXP_W(`DBL_EXP_W), .FRAC_W(`DBL_FRAC_W), .BIAS(`DBL_BIAS)) u_cls_b (
        .value (cmp_b),
        .cls   (b_if)
    );
    // Stored result in double format.
    fp_classify #(.EXP_W(`DBL_EXP_W), .FRAC_W(`DBL_FRAC_W), .BIAS(`DBL_BIAS)) u_cls_rd (
        .value (res_value),
        .cls   (rd_if)
    );
    // Stored result in single format, held in the upper word.
    fp_classify #(.EXP_W(`SGL_EXP_W), .FRAC_W(`SGL_FRAC_W), .BIAS(`SGL_BIAS)) u_cls_rs (
        .value (res_value[63:32]),
        .cls   (rs_if)
    );

    // Status word and its next value.
    logic [0:31] st_reg;
    logic [0:31] st_next;
    // Trap request and copied nibble.
    logic        trap_reg;
    logic        trap_next;
    logic [0:3]  copy_reg;
    logic [0:3]  copy_next;

    // Maps a value class and sign to the five-bit result flag code.
    function automatic logic [0:4] flags_of(input logic sgn, input val_class_t c);
        case (c)
            CLS_QNAN, CLS_SNAN: flags_of = `FLAGS_QNAN;
            CLS_INF:  flags_of = sgn ? `FLAGS_NINF  : `FLAGS_PINF;
            CLS_NORM: flags_of = sgn ? `FLAGS_NNORM : `FLAGS_PNORM;
            CLS_DEN:  flags_of = sgn ? `FLAGS_NDEN  : `FLAGS_PDEN;
            CLS_ZERO: flags_of = sgn ? `FLAGS_NZERO : `FLAGS_PZERO;
            default:  flags_of = `FLAGS_QNAN;
        endcase
    endfunction

    // Turns a sign-magnitude double into a signed ordering key; both zeros map to zero.
    function automatic logic signed [63:0] order_key(input logic [63:0] v);
        logic [63:0] mag;
        mag = {1'b0, v[62:0]};
        order_key = v[63] ? -$signed(mag) : $signed(mag);
    endfunction

    // Spreads a nibble mask over the 32 status bits.
    function automatic logic [0:31] expand(input logic [0:7] nm);
        expand = '0;
        for (int i = 0; i < 8; i++) begin
            expand[4*i +: 4] = {4{nm[i]}};
        end
    endfunction

    // Compare decode; a NaN on either side forces unordered.
    wire a_nan = (a_if.cls == CLS_QNAN) || (a_if.cls == CLS_SNAN);
    wire b_nan = (b_if.cls == CLS_QNAN) || (b_if.cls == CLS_SNAN);
    wire unord = a_nan || b_nan;
    wire signed [63:0] key_a = order_key(cmp_a);
    wire signed [63:0] key_b = order_key(cmp_b);
    wire [0:3] cmp_cc = unord           ? 4'h1 :
                        (key_a < key_b) ? 4'h8 :
                        (key_a > key_b) ? 4'h4 : 4'h2;

    // Result class code of the stored value in the chosen format.
    wire [0:4] res_flags = res_single ? flags_of(rs_if.sign, rs_if.cls)
                                      : flags_of(rd_if.sign, rd_if.cls);

    // Move decode: one-hot nibble and bit selects.
    wire [0:7]  fld_oh = 8'h80 >> mv_field;
    wire [0:31] bit_oh = 32'h8000_0000 >> mv_bit;
    // Bits that the move alters.
    wire [0:31] mv_wmask = (mv_op == MV_FIELDS)    ? expand(mv_mask) :
                           (mv_op == MV_FIELD_IMM) ? expand(fld_oh) :
                           (mv_op == MV_BIT_CLR)   ? bit_oh :
                           (mv_op == MV_BIT_SET)   ? bit_oh :
                           (mv_op == MV_COPY)      ? (expand(fld_oh) & `ST_STICKY) : '0;
    // Values that the move writes into those bits.
    wire [0:31] mv_wval  = (mv_op == MV_FIELDS)    ? mv_data :
                           (mv_op == MV_FIELD_IMM) ? {8{mv_imm}} :
                           (mv_op == MV_BIT_SET)   ? '1 : '0;
    // Status after the move; reserved bits and the FEX and VX summaries cannot be written.
    wire [0:31] after_mv = ((st_reg & ~mv_wmask) | (mv_wval & mv_wmask))
                           & `ST_WR_MASK;

    // Exception bits raised by this update.
    wire [0:31] hw_set = upd_valid ? {3'h0, exc_set, 9'h0, inv_sqrt, inv_cvt, 8'h0} : '0;
    // Exceptions that were clear before and are raised now.
    wire        new_exc = |(hw_set & ~st_reg);

    // Next status word: move first, then hardware sets, then summaries.
    always_comb begin
        logic [0:31] s;
        logic        vx;
        vx = 1'b0;
        s = after_mv;
        // A hardware set wins over a clear in the same cycle.
        s = s | hw_set;
        // The exception summary records any newly raised exception.
        if (new_exc) begin
            s[`ST_FX] = 1'b1;
        end
        // Compare writes only the condition code; others write the result flags.
        if (upd_valid && upd_compare) begin
            s[`ST_CC_LO:`ST_CC_HI] = cmp_cc;
        end else if (upd_valid) begin
            s[`ST_CLASS:`ST_CC_HI] = res_flags;
            s[`ST_FR] = frac_rounded;
            s[`ST_FI] = frac_inexact;
        end
        // Invalid summary follows the individual invalid bits.
        vx = (|s[`ST_VX_LO:`ST_VX_HI]) | s[`ST_VXSQRT] | s[`ST_VXCVI];
        s[`ST_VX] = vx;
        // Enabled summary gates each exception by its enable.
        s[`ST_FEX] = |({vx, s[`ST_OX:`ST_XX]} & s[`ST_EN_LO:`ST_EN_HI]);
        st_next = s;
    end

    // Trap request when this update raises an enabled exception.
    wire hw_vx = (|hw_set[`ST_VX_LO:`ST_VX_HI]) | hw_set[`ST_VXSQRT] | hw_set[`ST_VXCVI];
    assign trap_next = |({hw_vx, hw_set[`ST_OX:`ST_XX]}
                         & st_next[`ST_EN_LO:`ST_EN_HI]);
    // Copy-status captures the selected nibble before it is cleared.
    assign copy_next = (mv_op == MV_COPY) ? st_reg[4*mv_field +: 4] : copy_reg;

    // Status word register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= `ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Trap pulse and copied field registers.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trap_reg <= 1'b0;
            copy_reg <= 4'h0;
        end else begin
            trap_reg <= trap_next;
            copy_reg <= copy_next;
        end
    end

    // Outputs come straight from the registers.
    assign status_word   = st_reg;
    assign rounding_mode = round_mode_t'(st_reg[`ST_RND_LO:`ST_RND_HI]);
    assign exc_enables   = st_reg[`ST_EN_LO:`ST_EN_HI];
    assign trap_pulse    = trap_reg;
    assign copy_field    = copy_reg;

    // Checks on the status behaviour.
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // A compare update with no move in the same cycle.
    sequence cmp_upd_s;
        upd_valid && upd_compare && (mv_op == MV_NONE);
    endsequence

    // A result update in double format with no move in the same cycle.
    sequence res_upd_s;
        upd_valid && !upd_compare && !res_single && (mv_op == MV_NONE);
    endsequence

    // A result update in single format with no move in the same cycle.
    sequence sgl_upd_s;
        upd_valid && !upd_compare && res_single && (mv_op == MV_NONE);
    endsequence

    cc_onehot_a:
        assert property (cmp_upd_s |=> $onehot(status_word[`ST_CC_LO:`ST_CC_HI]))
        else $error("compare did not leave exactly one condition bit");

    cc_nan_a:
        assert property (cmp_upd_s ##0 (a_nan || b_nan) |=> status_word[`ST_CC_HI])
        else $error("NaN compare did not report unordered");

    cc_less_a:
        assert property (cmp_upd_s ##0 (!cmp_a[63] && !cmp_b[63] && !a_nan && !b_nan
                         && (cmp_a < cmp_b)) |=> status_word[`ST_CC_LO])
        else $error("less-than not at bit 16");

    flags_qnan_a:
        assert property (res_upd_s ##0 (rd_if.cls == CLS_QNAN)
                         |=> status_word[`ST_CLASS:`ST_CC_HI] == `FLAGS_QNAN)
        else $error("quiet NaN result flags wrong");

    flags_pnorm_a:
        assert property (res_upd_s ##0 (rd_if.cls == CLS_NORM && !rd_if.sign)
                         |=> status_word[`ST_CLASS:`ST_CC_HI] == `FLAGS_PNORM)
        else $error("positive normalized result flags wrong");

    flags_neg_a:
        assert property (res_upd_s ##0 (rd_if.sign && rd_if.cls != CLS_ZERO
                         && rd_if.cls != CLS_QNAN && rd_if.cls != CLS_SNAN)
                         |=> status_word[`ST_CC_LO])
        else $error("negative result lost its less-than meaning");

    sticky_hold_a:
        assert property ((mv_op == MV_NONE) |=>
                         ((status_word & $past(status_word) & `ST_STICKY)
                          == ($past(status_word) & `ST_STICKY)))
        else $error("sticky exception bit cleared without a move");

    sqrt_flag_a:
        assert property (upd_valid && inv_sqrt |=> status_word[`ST_VXSQRT] && status_word[`ST_VX])
        else $error("invalid square root not recorded");

    cvt_flag_a:
        assert property (upd_valid && inv_cvt |=> status_word[`ST_VXCVI] && status_word[`ST_VX])
        else $error("invalid integer convert not recorded");

    zdiv_gate_a:
        assert property (upd_valid && exc_set[5] && status_word[27] && (mv_op == MV_NONE)
                         |=> trap_pulse && status_word[`ST_FEX])
        else $error("enabled zero divide did not raise a trap");

    round_neg_a:
        assert property ((mv_op == MV_FIELD_IMM) && (mv_field == 3'h7) && (mv_imm[2:3] == 2'h3)
                         |=> rounding_mode == RND_NEG_INF)
        else $error("rounding code 11 did not select toward negative infinity");

    reserved_zero_a:
        assert property ((mv_op == MV_BIT_SET) |=> !status_word[20] && !status_word[21]
                         && !status_word[29])
        else $error("reserved status bit became set");

    // Classifier fields of the stored result.
    dbl_exp_a:
        assert property (res_upd_s ##0 (rd_if.cls == CLS_NORM || rd_if.cls == CLS_DEN)
                         |-> rd_if.exp_unb >= -1022 && rd_if.exp_unb <= 1023)
        else $error("double exponent out of range");

    sgl_exp_a:
        assert property (sgl_upd_s ##0 (rs_if.cls == CLS_NORM || rs_if.cls == CLS_DEN)
                         |-> rs_if.exp_unb >= -126 && rs_if.exp_unb <= 127)
        else $error("single exponent out of range");

    dbl_unit_a:
        assert property (res_upd_s ##0 (rd_if.cls == CLS_NORM || rd_if.cls == CLS_DEN)
                         |-> rd_if.signif == {rd_if.cls == CLS_NORM, res_value[51:0]})
        else $error("double significand wrong");

    sgl_unit_a:
        assert property (sgl_upd_s ##0 (rs_if.cls == CLS_NORM || rs_if.cls == CLS_DEN)
                         |-> rs_if.signif == {rs_if.cls == CLS_NORM, res_value[54:32], 29'h0})
        else $error("single significand wrong");

    // Compare keeps FR, FI and the class bit; then trap, copy and two more class code checks.
    cmp_keep_a:
        assert property (cmp_upd_s
                         |=> $stable(status_word[`ST_FR:`ST_CLASS]))
        else $error("compare altered class or rounding bits");

    trap_quiet_a:
        assert property (!upd_valid |=> !trap_pulse)
        else $error("trap raised without an update");

    copy_old_a:
        assert property ((mv_op == MV_COPY)
                         |=> copy_field == $past(status_word[4*mv_field +: 4]))
        else $error("copy did not return the old field");

    flags_pden_a:
        assert property (res_upd_s ##0 (rd_if.cls == CLS_DEN && !rd_if.sign)
                         |=> status_word[`ST_CLASS:`ST_CC_HI] == `FLAGS_PDEN)
        else $error("positive denormalized result flags wrong");

    flags_nzero_a:
        assert property (res_upd_s ##0 (rd_if.cls == CLS_ZERO && rd_if.sign)
                         |=> status_word[`ST_CLASS:`ST_CC_HI] == `FLAGS_NZERO)
        else $error("negative zero result flags wrong");

endmodule

// [fp_status_regs.svh]
// Bit positions, format widths, result flag codes and reset values of the status block.
`ifndef FP_STATUS_REGS_SVH
`define FP_STATUS_REGS_SVH

// Status positions; bit 0 is the most significant bit of the word.
`define ST_FX        0
`define ST_FEX       1
`define ST_VX        2
`define ST_OX        3
`define ST_XX        6
`define ST_VX_LO     7
`define ST_VX_HI     12
`define ST_FR        13
`define ST_FI        14
`define ST_CLASS     15
`define ST_CC_LO     16
`define ST_CC_HI     19
`define ST_VXSQRT    22
`define ST_VXCVI     23
`define ST_EN_LO     24
`define ST_EN_HI     28
`define ST_RND_LO    30
`define ST_RND_HI    31

// Writable bits, sticky exception bits and the reset value.
`define ST_WR_MASK   32'h9fff_f3fb
`define ST_STICKY    32'h9ff8_0300
`define ST_RESET     32'h0000_0000

// Result flag codes, class bit first, then less, greater, equal, unordered.
`define FLAGS_QNAN   5'h11
`define FLAGS_NINF   5'h09
`define FLAGS_NNORM  5'h08
`define FLAGS_NDEN   5'h18
`define FLAGS_NZERO  5'h12
`define FLAGS_PZERO  5'h02
`define FLAGS_PDEN   5'h17
`define FLAGS_PNORM  5'h04
`define FLAGS_PINF   5'h05

// Binary format layouts and biases.
`define SGL_EXP_W    8
`define SGL_FRAC_W   23
`define SGL_BIAS     127
`define DBL_EXP_W    11
`define DBL_FRAC_W   52
`define DBL_BIAS     1023

`endif

// [fp_status_pkg.sv]
// Types shared by the status block and its value classifier.
package fp_status_pkg;
    // Class of a stored floating-point value.
    typedef enum logic [2:0] {CLS_ZERO, CLS_DEN, CLS_NORM, CLS_INF, CLS_QNAN, CLS_SNAN} val_class_t;
    // Rounding control, in the order of its two-bit encoding.
    typedef enum logic [1:0] {RND_NEAREST, RND_ZERO, RND_POS_INF, RND_NEG_INF} round_mode_t;
    // Move-to-status and copy-status instructions from the sequencer.
    typedef enum logic [2:0] {MV_NONE, MV_FIELDS, MV_FIELD_IMM, MV_BIT_CLR, MV_BIT_SET,
                              MV_COPY} mv_op_t;
endpackage

// [fp_class_if.sv]
// Classification of one floating-point value, passed from classifier to status block.
`timescale 1ns/1ps
interface fp_class_if;
    import fp_status_pkg::*;
    logic               sign;     // Sign bit of the value.
    val_class_t         cls;      // Value class.
    logic signed [12:0] exp_unb;  // Unbiased exponent.
    logic [52:0]        signif;   // Implied unit bit and fraction, left aligned.
    modport src (output sign, output cls, output exp_unb, output signif);
    modport dst (input sign, input cls, input exp_unb, input signif);
endinterface

// [fp_classify.sv]
// Combinational classifier for one single or double format value.
`timescale 1ns/1ps
`include "fp_status_regs.svh"
module fp_classify
    import fp_status_pkg::*;
#(
    parameter int EXP_W  = `DBL_EXP_W,
    parameter int FRAC_W = `DBL_FRAC_W,
    parameter int BIAS   = `DBL_BIAS
) (
    // Raw value, sign in the most significant bit.
    input wire logic [EXP_W+FRAC_W:0] value,
    // Classification result.
    fp_class_if.src                   cls
);
    // Field split: sign, biased exponent, fraction down to the last bit.
    wire              sign_bit  = value[EXP_W+FRAC_W];
    wire [EXP_W-1:0]  exp_f     = value[FRAC_W +: EXP_W];
    wire [FRAC_W-1:0] frac      = value[FRAC_W-1:0];
    wire              exp_zero  = (exp_f == '0);
    wire              exp_max   = (exp_f == '1);
    wire              frac_zero = (frac == '0);
    wire              quiet     = frac[FRAC_W-1];

    // Zero and denormal share exponent zero; maximum exponent is infinity or NaN.
    assign cls.sign = sign_bit;
    assign cls.cls  = exp_zero ? (frac_zero ? CLS_ZERO : CLS_DEN) :
                      exp_max  ? (frac_zero ? CLS_INF :
                                  (quiet ? CLS_QNAN : CLS_SNAN)) : CLS_NORM;
    // Denormals take the minimum exponent one minus the bias.
    assign cls.exp_unb = exp_zero ? 13'(1 - BIAS)
                                  : 13'(int'(exp_f) - BIAS);
    // Implied unit bit is one only for nonzero exponents.
    assign cls.signif = 53'({~exp_zero, frac}) << (`DBL_FRAC_W - FRAC_W);
endmodule

// [exec_unit_model.sv]
// Model of the execution unit and sequencer that feed the status block.
`timescale 1ns/1ps
module exec_unit_model
    import fp_status_pkg::*;
(
    // Clock.
    input  wire logic   clk,
    // Update requests.
    output logic        upd_valid,
    output logic        upd_compare,
    output logic [63:0] cmp_a,
    output logic [63:0] cmp_b,
    output logic [63:0] res_value,
    output logic        res_single,
    output logic [3:12] exc_set,
    output logic        inv_sqrt,
    output logic        inv_cvt,
    output logic        frac_rounded,
    output logic        frac_inexact,
    // Move and copy requests.
    output mv_op_t      mv_op,
    output logic [0:31] mv_data,
    output logic [0:7]  mv_mask,
    output logic [2:0]  mv_field,
    output logic [0:3]  mv_imm,
    output logic [4:0]  mv_bit
);
    // Every request line is quiet at time zero.
    initial begin
        {upd_valid, upd_compare, res_single, inv_sqrt, inv_cvt} = '0;
        {frac_rounded, frac_inexact, cmp_a, cmp_b, res_value, exc_set} = '0;
        {mv_data, mv_mask, mv_field, mv_imm, mv_bit} = '0;
        mv_op = MV_NONE;
    end
    // Drops both requests at the next falling edge, so each one lasts one cycle.
    task automatic idle();
        @(negedge clk);
        upd_valid = 1'b0;
        mv_op     = MV_NONE;
    endtask
    // Issues one update; operands always travel in the double layout.
    task automatic upd(input logic c, input logic [63:0] a, input logic [63:0] b,
                       input logic [63:0] r, input logic s, input logic [3:12] x,
                       input logic q, input logic v, input logic rup, input logic inx);
        @(negedge clk);
        upd_valid    = 1'b1;
        upd_compare  = c;
        cmp_a        = a;
        cmp_b        = b;
        res_value    = r;
        res_single   = s;
        exc_set      = x;
        inv_sqrt     = q;
        inv_cvt      = v;
        frac_rounded = rup;
        frac_inexact = inx;
    endtask
    // Issues one move or copy request.
    task automatic mv(input mv_op_t op, input logic [0:31] d, input logic [0:7] k,
                      input logic [2:0] f, input logic [0:3] im, input logic [4:0] b);
        @(negedge clk);
        mv_op    = op;
        mv_data  = d;
        mv_mask  = k;
        mv_field = f;
        mv_imm   = im;
        mv_bit   = b;
    endtask
endmodule

// [tb.sv]
// Self-checking bench for the status block against a behavioural model.
`timescale 1ns/1ps
module tb
    import fp_status_pkg::*;
;
    // Design connections.
    logic        clk = 1'b0;
    logic        nrst;
    logic        upd_valid, upd_compare, res_single, inv_sqrt, inv_cvt;
    logic        frac_rounded, frac_inexact, trap_pulse;
    logic [63:0] cmp_a, cmp_b, res_value;
    logic [3:12] exc_set;
    mv_op_t      mv_op;
    logic [0:31] mv_data, status_word;
    logic [0:7]  mv_mask;
    logic [2:0]  mv_field;
    logic [0:3]  mv_imm, copy_field;
    logic [4:0]  mv_bit;
    round_mode_t rounding_mode;
    logic [0:4]  exc_enables;
    // Model state, random source and counters.
    logic [0:31] m;
    logic [0:3]  mcopy;
    logic        mtrap;
    logic [31:0] seed = 32'h0001_3afd;
    int          n_errors = 0;
    int          tests_run = 0;

    exec_unit_model eu (.clk, .upd_valid, .upd_compare, .cmp_a, .cmp_b, .res_value,
        .res_single, .exc_set, .inv_sqrt, .inv_cvt, .frac_rounded, .frac_inexact,
        .mv_op, .mv_data, .mv_mask, .mv_field, .mv_imm, .mv_bit);
    fp_status_control dut (.clk, .nrst, .upd_valid, .upd_compare, .cmp_a, .cmp_b,
        .res_value, .res_single, .exc_set, .inv_sqrt, .inv_cvt, .frac_rounded,
        .frac_inexact, .mv_op, .mv_data, .mv_mask, .mv_field, .mv_imm, .mv_bit,
        .status_word, .rounding_mode, .exc_enables, .trap_pulse, .copy_field);

    // Clock of 8 ns.
    always #4 clk = ~clk;

    // Shift register source of random values.
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // A double value with all-ones exponent and nonzero fraction.
    function automatic logic nan(input logic [63:0] a);
        return a[62:52] == 11'h7ff && a[51:0] != '0;
    endfunction
    // Expected compare code: less, greater, equal, unordered.
    function automatic logic [0:3] cc(input logic [63:0] a, input logic [63:0] b);
        if (nan(a) || nan(b)) return 4'h1;
        if ($bitstoreal(a) < $bitstoreal(b)) return 4'h8;
        if ($bitstoreal(a) > $bitstoreal(b)) return 4'h4;
        return 4'h2;
    endfunction
    // Expected class code of a stored result, single layout in the upper word.
    function automatic logic [0:4] flags(input logic [63:0] r, input logic s);
        int e;
        int emax;
        logic fz;
        e = s ? int'(r[62:55]) : int'(r[62:52]);
        emax = s ? 255 : 2047;
        fz = s ? (r[54:32] == '0) : (r[51:0] == '0);
        if (e == emax) return fz ? (r[63] ? 5'h09 : 5'h05) : 5'h11;
        if (e != 0) return r[63] ? 5'h08 : 5'h04;
        if (fz) return r[63] ? 5'h12 : 5'h02;
        return r[63] ? 5'h18 : 5'h17;
    endfunction
    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Ends the request, refreshes the summaries and compares every output.
    task automatic check_all();
        eu.idle();
        m[2] = |{m[7:12], m[22:23]};
        m[1] = (m[2] & m[24]) | (|(m[3:6] & m[25:28]));
        chk("flags", 32'(status_word[15:19]), 32'(m[15:19]));
        chk("status", status_word, m);
        chk("invalid", 32'(status_word[22:23]), 32'(m[22:23]));
        chk("sticky", 32'(status_word[3:12]), 32'(m[3:12]));
        chk("enables", 32'(exc_enables), 32'(m[24:28]));
        chk("rounding", 32'(rounding_mode), 32'(m[30:31]));
        chk("trap", 32'(trap_pulse), 32'(mtrap));
        chk("copy", 32'(copy_field), 32'(mcopy));
    endtask
    // One update through the partner, mirrored in the model.
    task automatic do_upd(input logic c, input logic [63:0] a, input logic [63:0] b,
                          input logic [63:0] r, input logic s, input logic [3:12] x,
                          input logic q, input logic v);
        logic rup;
        logic inx;
        rup = 1'(rnd());
        inx = 1'(rnd() >> 3);
        eu.upd(c, a, b, r, s, x, q, v, rup, inx);
        mtrap = (|{x[7:12], q, v} & m[24]) | (|(x[3:6] & m[25:28]));
        if (|{x & ~m[3:12], q & ~m[22], v & ~m[23]}) m[0] = 1'b1;
        m[3:12] = m[3:12] | x;
        m[22] = m[22] | q;
        m[23] = m[23] | v;
        if (c) begin
            m[16:19] = cc(a, b);
        end else begin
            m[15:19] = flags(r, s);
            m[13:14] = {rup, inx};
        end
        check_all();
    endtask
    // One move or copy through the partner, mirrored in the model.
    task automatic do_mv(input mv_op_t op, input logic [0:31] d, input logic [0:7] k,
                         input logic [2:0] f, input logic [0:3] im, input logic [4:0] b);
        logic [0:31] w;
        logic [0:31] st;
        int j;
        w = 32'h9fff_f3fb; // FEX and VX summaries and reserved bits are not writable.
        st = 32'h9ff8_0300; // Sticky exception bits.
        eu.mv(op, d, k, f, im, b);
        mtrap = 1'b0;
        if (op == MV_COPY) mcopy = m[4*f +: 4];
        for (j = 0; j < 32; j++) begin
            if (op == MV_FIELDS && k[j/4] && w[j]) m[j] = d[j];
            if (op == MV_FIELD_IMM && j/4 == f && w[j]) m[j] = im[j%4];
            if ((op == MV_BIT_SET || op == MV_BIT_CLR) && j == b && w[j]) m[j] = op == MV_BIT_SET;
            if (op == MV_COPY && j/4 == f && st[j]) m[j] = 1'b0;
        end
        check_all();
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence: reset, rounding modes, class table, compares, random mix.
    initial begin
        logic [63:0] vals [12];
        int pa [5];
        int pb [5];
        int i;
        logic [63:0] a;
        vals = '{64'hfff8_0000_0000_0000, 64'hfff0_0000_0000_0000, 64'hbff0_0000_0000_0000,
                 64'h8000_0000_0000_0001, 64'h8000_0000_0000_0000, 64'h0, 64'h1,
                 64'h3ff0_0000_0000_0000, 64'h7ff0_0000_0000_0000, 64'h7ff0_0000_0000_0001,
                 64'h7f80_0000_0000_0000, 64'h0000_0001_0000_0000};
        pa = '{7, 8, 4, 0, 7};
        pb = '{8, 7, 5, 7, 9};
        nrst = 1'b0;
        m = '0;
        mcopy = '0;
        mtrap = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        check_all();
        // All four rounding modes, with a write attempt on reserved bit 29.
        for (i = 0; i < 4; i++) do_mv(MV_FIELD_IMM, '0, '0, 3'h7, {1'(rnd()), 1'b1, i[1:0]}, '0);
        // Every result class, double layout then two single values.
        for (i = 0; i < 12; i++) do_upd(1'b0, '0, '0, vals[i], i >= 10, '0, 1'b0, 1'b0);
        // Less, greater, signed zeros and unordered compares.
        for (i = 0; i < 5; i++) do_upd(1'b1, vals[pa[i]], vals[pb[i]], '0, 1'b0, '0, 1'b0, 1'b0);
        // Random mix of updates, moves, bit operations and copies.
        for (i = 0; i < 400; i++) begin
            a = {rnd(), rnd()};
            if (rnd() % 3 == 0) begin
                do_mv(mv_op_t'(3'(1 + rnd() % 5)), a[63:32], 8'(rnd()), 3'(1 + rnd() % 7),
                      4'(rnd()), 5'(rnd()));
            end else begin
                do_upd(1'(rnd()), a, {rnd(), rnd()}, a, 1'(rnd()), 10'(rnd() & rnd() & rnd()),
                       1'(rnd() & rnd()), 1'(rnd() & rnd()));
            end
        end
        stop_test();
    end

    // Cuts a hung run short.
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        stop_test();
    end
endmodule
